// [pkg/switch_memory_access_pkg.sv]
// constants, commands and carriers for the switch memory access block
package switch_memory_access_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_DATA   = 8'h00;
	localparam logic [7:0] ADDR_ADDR   = 8'h04;
	localparam logic [7:0] ADDR_CMD    = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_MODE   = 8'h10;
	localparam logic [7:0] ADDR_SUBCH  = 8'h14;
	// field positions
	localparam int STATUS_BUSY_BIT  = 0;
	localparam int MODE_STYLE_BIT   = 0;
	localparam int CMD_RW_BIT       = 7;
	localparam int ADDR_UP_BIT      = 7;
	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [3:0] RESET_CODE = 4'h0;
	// operation codes, command bits 6..3
	localparam logic [3:0] OP_CM_BOTH_A = 4'he;
	localparam logic [3:0] OP_CM_BOTH_B = 4'hf;
	localparam logic [3:0] OP_CM_DATA   = 4'h9;
	localparam logic [3:0] OP_DM_DATA   = 4'h1;
	localparam logic [3:0] OP_TS_ONE    = 4'hc;
	localparam logic [3:0] OP_TS_ALL    = 4'hd;
	// connection function codes
	localparam logic [3:0] FC_OFF   = 4'h0;
	localparam logic [3:0] FC_FULL  = 4'h1;
	localparam logic [3:0] FC_LO4   = 4'h2;
	localparam logic [3:0] FC_HI4   = 4'h3;
	localparam logic [3:0] FC_B10   = 4'h4;
	localparam logic [3:0] FC_B76   = 4'h7;
	localparam logic [3:0] FC_UP    = 4'h9;
	// idle write masks by command bits 5..3
	localparam logic [7:0] MASK_ALL = 8'hff;
	localparam logic [7:0] MASK_HI4 = 8'hf0;
	localparam logic [7:0] MASK_LO4 = 8'h0f;
	localparam logic [7:0] MASK_B76 = 8'hc0;
	localparam logic [7:0] MASK_B54 = 8'h30;
	localparam logic [7:0] MASK_B32 = 8'h0c;
	localparam logic [7:0] MASK_B10 = 8'h03;
	// timing
	localparam int REF_CYCLES_ALL = 1035;
	localparam int TS_ENTRIES     = 128;
	// access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_SWEEP = 3'b100
	} state_t;
	// one connection memory line
	typedef struct packed {
		logic [7:0] data;
		logic [3:0] code;
	} cm_entry_t;
	// downstream output timing from the switch
	typedef struct packed {
		logic [6:0] slot;
		logic [2:0] bit_pos;
	} cfi_pos_t;
endpackage : switch_memory_access_pkg

// [rtl/switch_memory_access.sv]
// memory access command interpreter with downstream output control
`timescale 1ns/1ps
module switch_memory_access (
	input  wire logic                                    clk_sys_i,
	input  wire logic                                    rst_b_i,
	input  wire logic                                    psel_i,
	input  wire logic                                    penable_i,
	input  wire logic                                    pwrite_i,
	input  wire logic [7:0]                              paddr_i,
	input  wire logic [31:0]                             pwdata_i,
	output logic      [31:0]                             prdata_o,
	output logic                                         pready_o,
	output logic                                         pslverr_o,
	input  wire logic                                    rx_we_i,
	input  wire logic [6:0]                              rx_addr_i,
	input  wire logic [7:0]                              rx_data_i,
	input  wire switch_memory_access_pkg::cfi_pos_t      cfi_pos_i,
	output logic                                         cfi_out_o,
	output logic                                         cfi_oe_o
);
	switch_memory_access_pkg::state_t    state;
	switch_memory_access_pkg::cm_entry_t connection_memory [256];
	switch_memory_access_pkg::cm_entry_t cm_rd;
	switch_memory_access_pkg::cm_entry_t cm_ds;
	logic [7:0]  data_memory [256];
	logic [3:0]  tristate_field [switch_memory_access_pkg::TS_ENTRIES];
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic [7:0]  mem_access_data_reg;
	logic [7:0]  mem_access_addr_reg;
	logic [7:0]  mem_access_cmd_reg;
	logic [7:0]  operation_mode_reg;
	logic [7:0]  subchannel_select_reg;
	logic [6:0]  sweep_idx;
	logic        mem_access_busy;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        cmd_read;
	logic [3:0]  memory_op_code;
	logic [3:0]  connection_function_code;
	logic [7:0]  idle_mask;
	logic [7:0]  src_byte;
	logic [2:0]  cfi_lo;
	logic [2:0]  pcm_lo;
	logic [2:0]  width_m1;
	logic [2:0]  rel;
	logic        in_win;
	logic        next_out;
	logic        next_oe;
	logic        active;
	logic        bit_val;

	// reset release through two flops
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// apb decode, zero wait states
	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_en    = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	always_comb begin
		case (paddr_i)
			switch_memory_access_pkg::ADDR_DATA,
			switch_memory_access_pkg::ADDR_ADDR,
			switch_memory_access_pkg::ADDR_CMD,
			switch_memory_access_pkg::ADDR_STATUS,
			switch_memory_access_pkg::ADDR_MODE,
			switch_memory_access_pkg::ADDR_SUBCH: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr_o = psel_i & penable_i & ~addr_ok;

	// read data mux
	always_comb begin
		prdata_o = 32'h0000_0000;
		if (rd_en) begin
			case (paddr_i)
				switch_memory_access_pkg::ADDR_DATA:   prdata_o[7:0] = mem_access_data_reg;
				switch_memory_access_pkg::ADDR_ADDR:   prdata_o[7:0] = mem_access_addr_reg;
				switch_memory_access_pkg::ADDR_CMD:    prdata_o[7:0] = mem_access_cmd_reg;
				switch_memory_access_pkg::ADDR_STATUS:
					prdata_o[switch_memory_access_pkg::STATUS_BUSY_BIT] = mem_access_busy;
				switch_memory_access_pkg::ADDR_MODE:   prdata_o[7:0] = operation_mode_reg;
				switch_memory_access_pkg::ADDR_SUBCH:  prdata_o[7:0] = subchannel_select_reg;
				default:                               prdata_o = 32'h0000_0000;
			endcase
		end
	end

	// command fields
	assign cmd_read                 = mem_access_cmd_reg[switch_memory_access_pkg::CMD_RW_BIT];
	assign memory_op_code           = mem_access_cmd_reg[6:3];
	assign connection_function_code = mem_access_cmd_reg[3:0];
	assign mem_access_busy          = (state != switch_memory_access_pkg::ST_IDLE);
	assign cm_rd                    = connection_memory[mem_access_addr_reg];

	// idle write mask from command bits 5..3
	always_comb begin
		case (mem_access_cmd_reg[5:3])
			3'h1:    idle_mask = switch_memory_access_pkg::MASK_ALL;
			3'h3:    idle_mask = switch_memory_access_pkg::MASK_HI4;
			3'h2:    idle_mask = switch_memory_access_pkg::MASK_LO4;
			3'h7:    idle_mask = switch_memory_access_pkg::MASK_B76;
			3'h6:    idle_mask = switch_memory_access_pkg::MASK_B54;
			3'h5:    idle_mask = switch_memory_access_pkg::MASK_B32;
			3'h4:    idle_mask = switch_memory_access_pkg::MASK_B10;
			default: idle_mask = 8'h00;
		endcase
	end

	// plain registers written by software
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_addr_reg   <= switch_memory_access_pkg::RESET_BYTE;
			operation_mode_reg    <= switch_memory_access_pkg::RESET_BYTE;
			subchannel_select_reg <= switch_memory_access_pkg::RESET_BYTE;
		end else if (wr_en) begin
			case (paddr_i)
				switch_memory_access_pkg::ADDR_ADDR:  mem_access_addr_reg   <= pwdata_i[7:0];
				switch_memory_access_pkg::ADDR_MODE:  operation_mode_reg    <= pwdata_i[7:0];
				switch_memory_access_pkg::ADDR_SUBCH: subchannel_select_reg <= pwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// command register, ignored while an access runs
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_cmd_reg <= switch_memory_access_pkg::RESET_BYTE;
		end else if (wr_en && paddr_i == switch_memory_access_pkg::ADDR_CMD && !mem_access_busy) begin
			mem_access_cmd_reg <= pwdata_i[7:0];
		end
	end

	// access sequencer: busy from the edge after the command write
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state     <= switch_memory_access_pkg::ST_IDLE;
			sweep_idx <= 7'h00;
		end else begin
			case (state)
				switch_memory_access_pkg::ST_IDLE: begin
					sweep_idx <= 7'h00;
					if (wr_en && paddr_i == switch_memory_access_pkg::ADDR_CMD) begin
						state <= switch_memory_access_pkg::ST_EXEC;
					end
				end
				switch_memory_access_pkg::ST_EXEC: begin
					if (!cmd_read && memory_op_code == switch_memory_access_pkg::OP_TS_ALL) begin
						state <= switch_memory_access_pkg::ST_SWEEP;
					end else begin
						state <= switch_memory_access_pkg::ST_IDLE;
					end
				end
				switch_memory_access_pkg::ST_SWEEP: begin
					// one entry a cycle, well inside the reference budget
					sweep_idx <= sweep_idx + 7'h01;
					if (sweep_idx == 7'h7f) begin
						state <= switch_memory_access_pkg::ST_IDLE;
					end
				end
				default: state <= switch_memory_access_pkg::ST_IDLE;
			endcase
		end
	end

	// data register: software writes, read results land here
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mem_access_data_reg <= switch_memory_access_pkg::RESET_BYTE;
		end else if (state == switch_memory_access_pkg::ST_EXEC && cmd_read) begin
			case (memory_op_code)
				switch_memory_access_pkg::OP_CM_BOTH_A,
				switch_memory_access_pkg::OP_CM_BOTH_B:
					mem_access_data_reg <= {4'h0, cm_rd.code};
				switch_memory_access_pkg::OP_CM_DATA:
					mem_access_data_reg <= cm_rd.data;
				switch_memory_access_pkg::OP_DM_DATA:
					mem_access_data_reg <= data_memory[mem_access_addr_reg];
				switch_memory_access_pkg::OP_TS_ONE:
					mem_access_data_reg <= {4'h0, tristate_field[mem_access_addr_reg[6:0]]};
				default: ;
			endcase
		end else if (wr_en && paddr_i == switch_memory_access_pkg::ADDR_DATA) begin
			mem_access_data_reg <= pwdata_i[7:0];
		end
	end

	// connection memory writes; codes cleared at reset so outputs start inactive
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 256; i++) begin
				connection_memory[i] <= '0;
			end
		end else if (state == switch_memory_access_pkg::ST_EXEC && !cmd_read) begin
			// host has already loaded the target line address
			if (memory_op_code[3:1] == switch_memory_access_pkg::OP_CM_BOTH_A[3:1]) begin
				connection_memory[mem_access_addr_reg] <=
					{mem_access_data_reg, connection_function_code};
			end else if (memory_op_code == switch_memory_access_pkg::OP_CM_DATA) begin
				connection_memory[mem_access_addr_reg].data <= mem_access_data_reg;
			end
		end
	end

	// data memory: idle writes upstream, received bytes downstream
	always_ff @(posedge clk_sys_i) begin
		if (state == switch_memory_access_pkg::ST_EXEC && !cmd_read
				&& memory_op_code[3] == 1'b0 && idle_mask != 8'h00) begin
			// idle writes always land in the upstream half
			data_memory[{1'b1, mem_access_addr_reg[6:0]}] <=
				(data_memory[{1'b1, mem_access_addr_reg[6:0]}] & ~idle_mask)
				| (mem_access_data_reg & idle_mask);
		end
		if (rx_we_i) begin
			data_memory[{1'b0, rx_addr_i}] <= rx_data_i;
		end
	end

	// tristate field, upstream only
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < switch_memory_access_pkg::TS_ENTRIES; i++) begin
				tristate_field[i] <= switch_memory_access_pkg::RESET_CODE;
			end
		end else if (state == switch_memory_access_pkg::ST_SWEEP) begin
			tristate_field[sweep_idx] <= mem_access_data_reg[3:0];
		end else if (state == switch_memory_access_pkg::ST_EXEC && !cmd_read
				&& memory_op_code == switch_memory_access_pkg::OP_TS_ONE) begin
			tristate_field[mem_access_addr_reg[6:0]] <= mem_access_data_reg[3:0];
		end
	end

	// downstream line for this cfi timeslot and its pointed-to byte
	assign cm_ds    = connection_memory[{1'b0, cfi_pos_i.slot}];
	assign src_byte = data_memory[{1'b0, cm_ds.data[6:0]}];

	// bit window from function code and subchannel select
	always_comb begin
		width_m1 = 3'd7;
		pcm_lo   = 3'd0;
		cfi_lo   = 3'd0;
		case (cm_ds.code)
			switch_memory_access_pkg::FC_FULL: begin
				width_m1 = 3'd7;
			end
			switch_memory_access_pkg::FC_HI4: begin
				width_m1 = 3'd3;
				pcm_lo   = 3'd4;
				cfi_lo   = {subchannel_select_reg[1], 2'b00};
			end
			switch_memory_access_pkg::FC_LO4: begin
				width_m1 = 3'd3;
				cfi_lo   = {subchannel_select_reg[1], 2'b00};
			end
			4'h4, 4'h5, 4'h6, 4'h7: begin
				width_m1 = 3'd1;
				pcm_lo   = {cm_ds.code[1:0], 1'b0};
				cfi_lo   = {subchannel_select_reg[1:0], 1'b0};
			end
			default: ;
		endcase
	end
	assign rel    = 3'(cfi_pos_i.bit_pos - cfi_lo);
	assign in_win = (cfi_pos_i.bit_pos >= cfi_lo) && (rel <= width_m1);

	// drive decision per code class
	always_comb begin
		active  = 1'b0;
		bit_val = 1'b1;
		if (cm_ds.code == switch_memory_access_pkg::FC_OFF) begin
			active = 1'b0;
		end else if (!cm_ds.code[3]) begin
			active  = in_win;
			bit_val = src_byte[3'(rel + pcm_lo)];
		end else begin
			// processor and preprocessed lines send their data field value
			active  = 1'b1;
			bit_val = cm_ds.data[cfi_pos_i.bit_pos];
		end
	end

	// output style selection
	always_comb begin
		if (operation_mode_reg[switch_memory_access_pkg::MODE_STYLE_BIT]) begin
			next_out = 1'b0;
			next_oe  = active & ~bit_val;
		end else begin
			next_out = bit_val;
			next_oe  = active;
		end
	end

	// registered pin drive
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			cfi_out_o <= 1'b0;
			cfi_oe_o  <= 1'b0;
		end else begin
			cfi_out_o <= next_out;
			cfi_oe_o  <= next_oe;
		end
	end
endmodule : switch_memory_access

// [tb/switch_memory_access_checker.sv]
// port assertions for the switch memory access block
`timescale 1ns/1ps
module switch_memory_access_checker (
	input  wire logic                               clk_sys_i,
	input  wire logic                               rst_b_i,
	input  wire logic                               psel_i,
	input  wire logic                               penable_i,
	input  wire logic                               pwrite_i,
	input  wire logic [7:0]                         paddr_i,
	input  wire logic [31:0]                        pwdata_i,
	input  wire logic [31:0]                        prdata_o,
	input  wire logic                               pready_o,
	input  wire logic                               pslverr_o,
	input  wire logic                               rx_we_i,
	input  wire logic [6:0]                         rx_addr_i,
	input  wire logic [7:0]                         rx_data_i,
	input  wire switch_memory_access_pkg::cfi_pos_t cfi_pos_i,
	input  wire logic                               cfi_out_o,
	input  wire logic                               cfi_oe_o
);
	logic       acc;
	logic       map;
	logic       od;
	logic [7:0] cnt;
	assign acc = psel_i & penable_i;
	assign map = paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	// output style and sweep length seen from bus writes
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			od  <= 1'b0;
			cnt <= 8'h00;
		end else begin
			if (acc && pwrite_i && paddr_i == 8'h10) od <= pwdata_i[0];
			if (cnt != 8'h00) cnt <= cnt - 8'h01;
			else if (acc && pwrite_i && paddr_i == 8'h08 && pwdata_i[7:0] == 8'h68) cnt <= 8'h81;
		end
	end
	property p_ready; pready_o; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_rd_idle; !(acc && !pwrite_i) |-> prdata_o == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read access");
	property p_rd_upper; prdata_o[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
	property p_err; acc && !map |-> pslverr_o; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped address");
	property p_no_err; acc && map |-> !pslverr_o; endproperty
	a_no_err: assert property (p_no_err) else $error("error on mapped address");
	property p_busy_sweep; acc && !pwrite_i && paddr_i == 8'h0c && cnt > 8'h02 |-> prdata_o[0]; endproperty
	a_busy_sweep: assert property (p_busy_sweep) else $error("busy low in sweep");
	property p_busy_clear; acc && !pwrite_i && paddr_i == 8'h0c && cnt == 8'h00 |-> !prdata_o[0]; endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy stuck high");
	property p_open_drain; od && $past(od) |-> !cfi_out_o; endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drives high");
	// main scenarios
	c_cmd: cover property (acc && pwrite_i && paddr_i == 8'h08);
	c_sweep: cover property (cnt == 8'h40 && acc);
	c_od: cover property (od && cfi_oe_o);
endmodule : switch_memory_access_checker
bind switch_memory_access switch_memory_access_checker i_checker (.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .rx_we_i(rx_we_i), .rx_addr_i(rx_addr_i), .rx_data_i(rx_data_i),
	.cfi_pos_i(cfi_pos_i), .cfi_out_o(cfi_out_o), .cfi_oe_o(cfi_oe_o));

// [tb/switch_memory_access_bench.sv]
// self-checking bench for the switch memory access block
`timescale 1ns/1ps
module switch_memory_access_bench;
	localparam logic [7:0] PCM = 8'hc6;
	localparam logic [7:0] PTR = 8'h5a;
	localparam logic [1:0] SUB = 2'b10;
	logic                               clk_sys;
	logic                               rst_b;
	logic                               psel;
	logic                               penable;
	logic                               pwrite;
	logic [7:0]                         paddr;
	logic [31:0]                        pwdata;
	logic [31:0]                        prdata;
	logic                               pready;
	logic                               pslverr;
	logic                               rx_we;
	logic [6:0]                         rx_addr;
	logic [7:0]                         rx_data;
	switch_memory_access_pkg::cfi_pos_t cfi_pos;
	logic                               cfi_out;
	logic                               cfi_oe;
	logic [31:0]                        rd;
	logic                               err;
	int                                 errors;
	int                                 num_checks;
	int                                 cycles;
	int                                 polls;
	logic [3:0] codes [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha,
		4'hb, 4'h0};
	logic [7:0] idle_cmd [7] = '{8'h08, 8'h18, 8'h10, 8'h38, 8'h30, 8'h28, 8'h20};
	logic [7:0] idle_mask [7] = '{8'hff, 8'hf0, 8'h0f, 8'hc0, 8'h30, 8'h0c, 8'h03};
	switch_memory_access i_dut (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_we_i(rx_we),
		.rx_addr_i(rx_addr), .rx_data_i(rx_data), .cfi_pos_i(cfi_pos), .cfi_out_o(cfi_out),
		.cfi_oe_o(cfi_oe));
	// free running clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// cycle ceiling against hangs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one transfer, held until pready at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// command write, then poll busy until clear
	task automatic cmd(input logic [7:0] c);
		apb(1'b1, 8'h08, {24'h0, c});
		polls = 0;
		do begin
			apb(1'b0, 8'h0c, 32'h0);
			polls++;
		end while (rd[0] !== 1'b0);
	endtask : cmd
	task automatic rd_chk(input logic [31:0] exp);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, exp);
	endtask : rd_chk
	task automatic cm_set(input logic [6:0] s, input logic [3:0] c, input logic [7:0] d);
		apb(1'b1, 8'h00, {24'h0, d});
		apb(1'b1, 8'h04, {25'h0, s});
		cmd({4'h7, c});
	endtask : cm_set
	task automatic rx_put(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		rx_we   <= 1'b1;
		rx_addr <= a;
		rx_data <= d;
		@(posedge clk_sys);
		rx_we <= 1'b0;
	endtask : rx_put
	// expected {out, oe} for the downstream pin
	function automatic logic [1:0] cfi_exp(input logic [3:0] c, input logic [2:0] bp,
		input logic od);
		logic a;
		logic b;
		a = c == 4'h0 ? 1'b0 : c[3:1] == 3'b001 ? bp[2] == SUB[1]
			: c[3:2] == 2'b01 ? bp[2:1] == SUB : 1'b1;
		b = c[3] ? PTR[bp] : c[3:1] == 3'b001 ? PCM[{c[0], bp[1:0]}]
			: c[3:2] == 2'b01 ? PCM[{c[1:0], bp[0]}] : PCM[bp];
		return od ? {1'b0, a & ~b} : {b, a};
	endfunction : cfi_exp
	task automatic t_reset();
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_cm();
		for (int i = 0; i < 12; i++) begin
			cm_set(7'(i), codes[i], 8'h40 + 8'(i));
			cmd({4'hf, ~codes[i]});
			rd_chk({28'h0, codes[i]});
			cmd(8'hc8);
			rd_chk({24'h0, 8'h40 + 8'(i)});
		end
		apb(1'b1, 8'h00, 32'h33);
		cmd(8'h48);
		cmd(8'hc8);
		rd_chk(32'h33);
		cmd(8'hf0);
		rd_chk({28'h0, codes[11]});
		$display("test connection memory done");
	endtask : t_cm
	task automatic t_dm();
		logic [7:0] e;
		logic [7:0] d;
		rx_put(7'h11, 8'h96);
		apb(1'b1, 8'h04, 32'h11);
		cmd(8'h88);
		rd_chk(32'h96);
		apb(1'b1, 8'h04, 32'h91);
		e = 8'h3c;
		for (int i = 0; i < 7; i++) begin
			d = ~e;
			e = (e & ~idle_mask[i]) | (d & idle_mask[i]);
			apb(1'b1, 8'h00, {24'h0, d});
			cmd(idle_cmd[i]);
			cmd(8'h88);
			rd_chk({24'h0, e});
		end
		$display("test data memory done");
	endtask : t_dm
	task automatic t_ts();
		apb(1'b1, 8'h04, 32'h8a);
		apb(1'b1, 8'h00, 32'hf9);
		cmd(8'h60);
		cmd(8'he0);
		rd_chk(32'h9);
		apb(1'b1, 8'h00, 32'h06);
		cmd(8'h68);
		chk({31'h0, polls inside {[40:45]}}, 32'h1);
		apb(1'b1, 8'h04, 32'hb3);
		cmd(8'he0);
		rd_chk(32'h6);
		$display("test tristate done");
	endtask : t_ts
	task automatic t_cfi();
		logic [1:0] e;
		apb(1'b1, 8'h14, {30'h0, SUB});
		rx_put(PTR[6:0], PCM);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, 8'h10, 32'(m));
			for (int i = 0; i < 12; i++) begin
				cm_set(7'h03, codes[i], PTR);
				for (int b = 0; b < 8; b++) begin
					@(posedge clk_sys);
					cfi_pos <= '{slot: 7'h03, bit_pos: 3'(b)};
					@(posedge clk_sys);
					@(negedge clk_sys);
					e = cfi_exp(codes[i], 3'(b), m[0]);
					chk({31'h0, cfi_oe}, {31'h0, e[0]});
					if (m[0] || e[0]) chk({31'h0, cfi_out}, {31'h0, e[1]});
				end
			end
		end
		$display("test output control done");
	endtask : t_cfi
	// reset, then scenarios in turn
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_we = 1'b0;
		rx_addr = 7'h00;
		rx_data = 8'h00;
		cfi_pos = '0;
		errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_cm();
		t_dm();
		t_ts();
		t_cfi();
		finish_test();
	end
endmodule : switch_memory_access_bench
